// ==== core/hssc_pkg.sv ====
package hssc_pkg;

    // clock and derived ticks
    localparam int SYS_CLK_HZ = 125000000;
    localparam int LOGIC_CLK_HZ = 250000;
    localparam int LOGIC_DIV = SYS_CLK_HZ / LOGIC_CLK_HZ;
    localparam int TICK_US = 4;
    localparam int TICK_LOGIC = TICK_US * LOGIC_CLK_HZ / 1000000;
    localparam int TICK_DIV = LOGIC_DIV * TICK_US * LOGIC_CLK_HZ / 1000000;
    localparam int PUMP_TIMER_US = 32;
    localparam int PUMP_TIMER_TICKS = PUMP_TIMER_US / TICK_US;
    localparam int SEQ_WAIT_NS = 15360000;
    localparam int SEQ_WAIT_CYC = SEQ_WAIT_NS / 8;

    // register map (avalon word addresses in bytes)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;

    // ctrl bits
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;

    // irq event bits
    localparam int IRQ_W = 4;
    localparam int EV_PGOOD = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_OVERCUR = 2;
    localparam int EV_DONE = 3;

    typedef enum logic [8:0] {
        HSSC_IDLE = 9'h001,
        HSSC_SETTLE = 9'h002,
        HSSC_ENABLE = 9'h004,
        HSSC_WAIT_RAIL = 9'h008,
        HSSC_RANGE = 9'h010,
        HSSC_RAMP = 9'h020,
        HSSC_PGOOD = 9'h040,
        HSSC_HOLD = 9'h080,
        HSSC_SHUTDOWN = 9'h100
    } hssc_state_t;

    typedef struct packed {
        logic primary_current_cmp;
        logic external_current_cmp;
        logic rail_voltage_reached;
        logic fast_overcurrent_in;
    } hssc_sense_t;

    typedef struct packed {
        logic pump_drive_out;
        logic rail_shutdown_out;
        logic pri_limit_select_n;
        logic ext_limit_select_n;
        logic power_good_n;
    } hssc_drive_t;

endpackage

// ==== core/hssc_pump.sv ====
`timescale 1ns/1ps
module hssc_pump import hssc_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // 4 us tick
    input wire logic i_tick,
    // modulation out
    output logic o_modulation
);
    logic [3:0] pump_timer;
    logic pump_timer_terminal;
    logic tc_stretch_flop;
    logic pump_timer_gate;

    assign pump_timer_terminal = (pump_timer == 4'(PUMP_TIMER_TICKS - 1));

    // stretch flop on the 4 us tick
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            tc_stretch_flop <= 1'b0;
            pump_timer_gate <= 1'b1;
        end else if (i_tick) begin
            tc_stretch_flop <= pump_timer_terminal & pump_timer_gate;
            pump_timer_gate <= ~tc_stretch_flop;
        end
    end

    // timer held while gate is low
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pump_timer <= 4'h0;
        end else if (i_tick && pump_timer_gate && !tc_stretch_flop) begin
            pump_timer <= pump_timer_terminal ? 4'h0 : pump_timer + 4'h1;
        end
    end

    // gate lags the stretch flop one tick, so the pair spans both held ticks
    assign o_modulation = pump_timer_gate & ~tc_stretch_flop;
endmodule

// ==== core/hssc_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - pump timing derives from a 250 kHz logic clock, 4 us tick; sequence waits count system clocks
// - pump timer terminal count captured by stretch flop on 4 us tick
// - timer gate loads inverse of stretch flop one tick later; pump period 40 us
// - modulation high 32 us, low 8 us each period
// - before rail voltage is reached, pump drive follows modulation only while both current comparators are low
// - once rail voltage reached, drive follows modulation regardless of current
// - step 3 waits up to 15.36 ms for rail voltage, else shutdown
// - step 4 drives both limit selects low, raising limit to 15 A
// - step 5 waits 15.36 ms unconditionally
// - step 6 drives power good low
// - step 7 waits 15.36 ms then sequence is done
// - external high on fast overcurrent input shuts the pass switch quickly
// - rail shutdown starts high, goes low to turn rail on
// - step 1 waits 15.36 ms, step 2 drives rail shutdown low
module hssc_top import hssc_pkg::*; #(
    // sequencer wait length in clocks
    parameter int WAIT_CYC = SEQ_WAIT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // analog comparators and sense
    input wire hssc_sense_t i_sense,
    // board drive
    output hssc_drive_t o_drive,
    // interrupt
    output logic o_irq
);
    hssc_state_t state;
    hssc_state_t next_state;
    logic [$clog2(LOGIC_DIV)-1:0] logic_div;
    logic logic_en;
    logic tick;
    logic [$clog2(WAIT_CYC)-1:0] wait_timer;
    logic wait_done;
    logic modulation;
    logic pump_drive_out;
    logic rail_shutdown_out;
    logic limit_select_n;
    logic power_good_n;
    logic start_req;
    logic abort_req;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic bus_ack;
    logic wr_stb;

    function automatic logic timed_step(input hssc_state_t s);
        return (s == HSSC_SETTLE) || (s == HSSC_WAIT_RAIL) || (s == HSSC_RAMP) || (s == HSSC_HOLD);
    endfunction

    // 250 kHz logic clock enable; its 4 us period is the registered-logic tick
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            logic_div <= '0;
        end else begin
            logic_div <= logic_en ? '0 : logic_div + 1'b1;
        end
    end
    assign logic_en = (logic_div == $bits(logic_div)'(LOGIC_DIV - 1));
    assign tick = logic_en;

    hssc_pump u_pump (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_tick(tick),
        .o_modulation(modulation)
    );

    // registered pump drive; cut at once on overcurrent or when rail is off
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pump_drive_out <= 1'b0;
        end else begin
            pump_drive_out <= modulation && !rail_shutdown_out && !i_sense.fast_overcurrent_in
                && ((!i_sense.primary_current_cmp && !i_sense.external_current_cmp)
                || i_sense.rail_voltage_reached);
        end
    end

    // wait timer restarts on every timed-step entry
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wait_timer <= '0;
        end else if (next_state != state || !timed_step(state)) begin
            wait_timer <= '0;
        end else if (!wait_done) begin
            wait_timer <= wait_timer + 1'b1;
        end
    end
    assign wait_done = (wait_timer == $bits(wait_timer)'(WAIT_CYC - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            HSSC_IDLE: if (start_req) next_state = HSSC_SETTLE;
            HSSC_SETTLE: if (wait_done) next_state = HSSC_ENABLE;
            HSSC_ENABLE: next_state = HSSC_WAIT_RAIL;
            HSSC_WAIT_RAIL: begin
                if (i_sense.rail_voltage_reached) next_state = HSSC_RANGE;
                else if (wait_done) next_state = HSSC_SHUTDOWN;
            end
            HSSC_RANGE: next_state = HSSC_RAMP;
            HSSC_RAMP: if (wait_done) next_state = HSSC_PGOOD;
            HSSC_PGOOD: next_state = HSSC_HOLD;
            HSSC_HOLD: if (wait_done) next_state = HSSC_IDLE;
            HSSC_SHUTDOWN: if (start_req) next_state = HSSC_SETTLE;
        endcase
        // idle too: a finished sequence leaves the rail on and still needs the trip
        if ((i_sense.fast_overcurrent_in || abort_req) && state != HSSC_SHUTDOWN) begin
            next_state = HSSC_SHUTDOWN;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= HSSC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // board outputs; all held in their safe level until sequenced
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rail_shutdown_out <= 1'b1;
            limit_select_n <= 1'b1;
            power_good_n <= 1'b1;
        end else begin
            if (next_state == HSSC_SHUTDOWN || next_state == HSSC_SETTLE) begin
                rail_shutdown_out <= 1'b1;
                limit_select_n <= 1'b1;
                power_good_n <= 1'b1;
            end else begin
                if (state == HSSC_ENABLE) rail_shutdown_out <= 1'b0;
                if (state == HSSC_RANGE) limit_select_n <= 1'b0;
                if (state == HSSC_PGOOD) power_good_n <= 1'b0;
            end
        end
    end

    assign o_drive.pump_drive_out = pump_drive_out;
    assign o_drive.rail_shutdown_out = rail_shutdown_out;
    assign o_drive.pri_limit_select_n = limit_select_n;
    assign o_drive.ext_limit_select_n = limit_select_n;
    assign o_drive.power_good_n = power_good_n;

    // bus: one wait cycle, answered on the second edge
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
        end
    end
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;
    assign wr_stb = i_avs_write && bus_ack;

    // ctrl bits self-clear; a write pulses them
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            start_req <= 1'b0;
            abort_req <= 1'b0;
        end else begin
            start_req <= wr_stb && i_avs_address == REG_CTRL && i_avs_writedata[CTRL_START];
            abort_req <= wr_stb && i_avs_address == REG_CTRL && i_avs_writedata[CTRL_ABORT];
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[EV_PGOOD] = (state == HSSC_PGOOD);
        irq_event[EV_TIMEOUT] = (state == HSSC_WAIT_RAIL) && (next_state == HSSC_SHUTDOWN)
            && !i_sense.fast_overcurrent_in;
        irq_event[EV_OVERCUR] = (next_state == HSSC_SHUTDOWN) && (state != HSSC_SHUTDOWN)
            && i_sense.fast_overcurrent_in;
        irq_event[EV_DONE] = (state == HSSC_HOLD) && (next_state == HSSC_IDLE);
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_stb && i_avs_address == REG_IRQ_STAT) begin
                irq_status <= (irq_status & ~i_avs_writedata[IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
            if (wr_stb && i_avs_address == REG_IRQ_MASK) begin
                irq_mask <= i_avs_writedata[IRQ_W-1:0];
            end
        end
    end
    assign o_irq = |(irq_status & irq_mask);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && !bus_ack) begin
            unique case (i_avs_address)
                REG_CTRL: o_avs_readdata <= '0;
                REG_STATUS: o_avs_readdata <= {14'h0, 9'(state), i_sense, pump_drive_out,
                    rail_shutdown_out, limit_select_n, power_good_n, modulation};
                REG_IRQ_STAT: o_avs_readdata <= {28'h0, irq_status};
                REG_IRQ_MASK: o_avs_readdata <= {28'h0, irq_mask};
                default: o_avs_readdata <= '0;
            endcase
        end
    end
endmodule

// ==== testbench/hot_swap_sequence_controller_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t mismatch", $time); end end
module hot_swap_sequence_controller_tb;
    import hssc_pkg::*;
    logic i_clk = 0, i_reset_n = 0, rd = 0, wr = 0, trip = 0, stall = 0;
    logic [3:0] addr = 4'h0, m;
    logic [31:0] wd = 32'h0, q, seed = 32'h5;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_irq;
    logic [1:0] noise = 2'h0;
    hssc_drive_t o_drive;
    hssc_sense_t sense;
    int miscompares = 0, cmp_count = 0, n;
    // short sequencer waits keep the run brief; pump timing stays real
    localparam int W = 3000;
    localparam int HI_CYC = PUMP_TIMER_US * 125;
    localparam int LO_CYC = 2 * TICK_US * 125;
    localparam int WAIT_LIM = 10000;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic irq_exp(logic [3:0] s, logic [3:0] k);
        return |(s & k);
    endfunction
    hssc_top #(.WAIT_CYC(W)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_sense(sense), .o_drive(o_drive), .o_irq(o_irq));
    hssc_board_model board (.i_clk(i_clk), .i_drive(o_drive), .i_trip(trip), .i_noise(noise), .o_sense(sense));
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    // random comparator chatter keeps the current gate busy; stall pins both high
    always @(posedge i_clk) noise <= 2'(xs()) | {2{stall}};
    task test_done;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wd <= d;
        // request stands until waitrequest is seen low at a rising edge
        do begin
            @(posedge i_clk);
            k++;
        end while (o_avs_waitrequest !== 1'b0 && k < 50);
        if (o_avs_waitrequest !== 1'b0) miscompares++;
        r = o_avs_readdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // bit 5 is the interrupt, 4..0 the drive struct
    task wait_sig(input int b, input logic v, output int k);
        logic [5:0] s;
        k = 0;
        s = {o_irq, o_drive};
        while (s[b] !== v && k < WAIT_LIM) begin
            @(negedge i_clk);
            s = {o_irq, o_drive};
            k++;
        end
        if (s[b] !== v) miscompares++;
    endtask
    initial begin
        // five sequencer waits, two pump periods and bus traffic fit well inside
        repeat (80000) @(posedge i_clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(negedge i_clk);
        `CHK(o_drive, 5'h0f)
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_IDLE)
        bus(1, 4'h6, xs(), q);
        bus(0, 4'h2, 0, q);
        `CHK(q, 32'h0)
        bus(0, REG_IRQ_MASK, 0, q);
        `CHK(q, 32'h0)
        bus(1, REG_CTRL, 32'h1 << CTRL_START, q);
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_SETTLE)
        bus(1, REG_CTRL, 32'h1 << CTRL_ABORT, q);
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_SHUTDOWN)
        bus(1, REG_CTRL, 32'h1 << CTRL_START, q);
        wait_sig(3, 1'b0, n);
        `CHK(n inside {[W - 8:W + 8]}, 1'b1)
        wait_sig(2, 1'b0, n);
        `CHK(o_drive[3:1], 3'h0)
        wait_sig(0, 1'b0, n);
        `CHK(n inside {[W - 8:W + 8]}, 1'b1)
        bus(0, REG_IRQ_STAT, 0, q);
        `CHK(q[3:0], 4'h1)
        `CHK(o_irq, 1'b0)
        m = 4'(xs()) | 4'h1;
        bus(1, REG_IRQ_MASK, 32'(m), q);
        @(negedge i_clk);
        `CHK(o_irq, irq_exp(4'h1, m))
        bus(1, REG_IRQ_STAT, 32'h1, q);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        bus(1, REG_IRQ_MASK, 32'h1 << EV_DONE, q);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        wait_sig(5, 1'b1, n);
        `CHK(n inside {[W - 100:W + 8]}, 1'b1)
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_IDLE)
        `CHK(o_drive.power_good_n, 1'b0)
        // rail is up, so the comparators no longer gate the drive
        wait_sig(4, 1'b0, n);
        wait_sig(4, 1'b1, n);
        wait_sig(4, 1'b0, n);
        `CHK(n, HI_CYC)
        wait_sig(4, 1'b1, n);
        `CHK(n, LO_CYC)
        bus(1, REG_IRQ_STAT, 32'hf, q);
        bus(1, REG_IRQ_MASK, 32'h1 << EV_OVERCUR, q);
        bus(1, REG_CTRL, 32'h1 << CTRL_START, q);
        trip <= 1'b1;
        wait_sig(5, 1'b1, n);
        `CHK(n <= 3, 1'b1)
        `CHK(o_drive.rail_shutdown_out, 1'b1)
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_SHUTDOWN)
        trip <= 1'b0;
        // reset while in shutdown leaves every board output at its safe level
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(negedge i_clk);
        `CHK(o_drive, 5'h0f)
        // stalled comparators keep the rail down until the wait runs out
        bus(1, REG_IRQ_MASK, 32'h1 << EV_TIMEOUT, q);
        stall <= 1'b1;
        bus(1, REG_CTRL, 32'h1 << CTRL_START, q);
        wait_sig(5, 1'b1, n);
        `CHK(n inside {[2 * W - 8:2 * W + 8]}, 1'b1)
        bus(0, REG_STATUS, 0, q);
        `CHK(q[17:9], HSSC_SHUTDOWN)
        bus(0, REG_IRQ_STAT, 0, q);
        `CHK(q[3:0], 4'h2)
        stall <= 1'b0;
        test_done();
    end
endmodule

// ==== testbench/hssc_board_model.sv ====
`timescale 1ns/1ps
module hssc_board_model import hssc_pkg::*; (
    // board inputs
    input wire logic i_clk,
    input wire hssc_drive_t i_drive,
    input wire logic i_trip,
    input wire logic [1:0] i_noise,
    // comparators
    output hssc_sense_t o_sense
);
    localparam int unsigned RAIL_CHARGE = 100;
    int unsigned charge = 0;
    // rail charges only while pumped and switch enabled
    always @(posedge i_clk) begin
        if (i_drive.rail_shutdown_out) charge <= 0;
        else if (i_drive.pump_drive_out && charge < RAIL_CHARGE) charge <= charge + 1;
    end
    always_comb begin
        o_sense.rail_voltage_reached = (charge >= RAIL_CHARGE);
        o_sense.primary_current_cmp = i_noise[0];
        o_sense.external_current_cmp = i_noise[1];
        o_sense.fast_overcurrent_in = i_trip;
    end
endmodule

// ==== testbench/hssc_monitor.sv ====
`timescale 1ns/1ps
module hssc_monitor import hssc_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // bus
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // board
    input wire hssc_sense_t i_sense,
    input wire hssc_drive_t o_drive,
    input wire logic o_irq
);
    int unsigned hi_run;
    // length of the current high run of the pump drive
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !o_drive.pump_drive_out) begin
            hi_run <= 0;
        end else begin
            hi_run <= hi_run + 1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_req_new;
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
    endsequence
    sequence s_req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    a_wait_first: assert property (s_req_new |-> o_avs_waitrequest) else $error("no wait state");
    a_wait_one: assert property (s_req_wait |=> !o_avs_waitrequest) else $error("wait too long");
    a_reset_drive: assert property (disable iff (1'b0) !i_reset_n |=> o_drive == 5'h0f)
        else $error("bad reset drive");
    a_pump_gate: assert property (o_drive.pump_drive_out |-> $past(i_sense.rail_voltage_reached
        || !(i_sense.primary_current_cmp || i_sense.external_current_cmp))) else $error("pump not gated");
    // a full run of eight ticks is legal, so the count may reach it exactly
    a_pump_high: assert property (hi_run <= PUMP_TIMER_TICKS * TICK_DIV) else $error("pump high too long");
    a_pump_shut: assert property (o_drive.pump_drive_out |-> !$past(o_drive.rail_shutdown_out))
        else $error("pump while off");
    a_trip_off: assert property (i_sense.fast_overcurrent_in && !o_drive.rail_shutdown_out |-> ##[1:2]
        (o_drive.rail_shutdown_out && !o_drive.pump_drive_out && o_drive.power_good_n)) else $error("no trip");
    a_pgood_order: assert property (!o_drive.power_good_n |-> o_drive[3:1] == 3'h0)
        else $error("pgood early");
    a_limit_order: assert property (!o_drive.pri_limit_select_n || !o_drive.ext_limit_select_n
        |-> !o_drive.rail_shutdown_out) else $error("limit early");
endmodule
bind hssc_top hssc_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_sense(i_sense),
    .o_drive(o_drive), .o_irq(o_irq));
